// ### flash_cmd_host.sv
// Host controller that reads, programs and bulk-erases a byte-wide flash over its pins
`default_nettype none

// What this block does
// - Erase and program each need a setup write then the operation write.
// - Host keeps strobes non-writing from the third clock edge after logic supply falls below the lockout threshold.
// - Host starts a write with chip select and write strobe low, output enable high.
// - Host keeps output enable high during command writes; it drives it low for each read and status poll.
module flash_cmd_host
    import flash_host_pkg::*;
#(
    parameter logic [DATA_W-1:0] CMD_PROG_SETUP  = 8'h01,
    parameter logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h02,
    parameter logic [DATA_W-1:0] CMD_ERASE       = 8'h03,
    parameter logic [23:0]       POLL_LIMIT      = 24'hFFFFFF
) (
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire flash_host_pkg::req_t            req,
    output flash_host_pkg::resp_t                resp,
    output flash_host_pkg::pin_out_t             pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_lines_in,
    input  wire logic                            supply_ok
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VPP,
        ST_WR,
        ST_RD,
        ST_CHK,
        ST_FIN
    } state_t;

    typedef struct packed {
        state_t            st;
        logic [7:0]        cnt;
        logic              wr_idx;
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [23:0]       polls;
        logic              fail;
        pin_out_t          pin;
        resp_t             rsp;
    } host_t;

    localparam host_t HOST_RESET = '{st: ST_IDLE, cnt: '0, wr_idx: 1'b0, op: OP_READ,
                                     addr: '0, wdata: '0, polls: '0, fail: 1'b0,
                                     pin: PIN_IDLE, rsp: RESP_IDLE};

    host_t             s_ff;
    host_t             nxt_s;
    logic [DATA_W-1:0] dq_sync;
    logic              supply_sync;

    // Pins from the device side pass two flip-flops before use
    sync2 #(
        .W (DATA_W + 1)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({supply_ok, data_lines_in}),
        .q      ({supply_sync, dq_sync})
    );

    // Byte driven on the first or second write of a command pair
    function automatic logic [DATA_W-1:0] cmd_byte(input op_t op, input logic second,
                                                   input logic [DATA_W-1:0] data);
        if (op == OP_ERASE) begin
            cmd_byte = second ? CMD_ERASE : CMD_ERASE_SETUP;
        end else begin
            cmd_byte = second ? data : CMD_PROG_SETUP;
        end
    endfunction : cmd_byte

    // Status bit matches the target once the internal sequence has finished
    function automatic logic poll_done(input op_t op, input logic [DATA_W-1:0] wdata,
                                       input logic [DATA_W-1:0] rdata);
        if (op == OP_ERASE) begin
            poll_done = rdata[POLL_BIT];
        end else begin
            poll_done = (rdata[POLL_BIT] == wdata[POLL_BIT]);
        end
    endfunction : poll_done

    // Accept a request only when idle and the logic supply is good
    assign req_ready = (s_ff.st == ST_IDLE) && supply_sync;

    // Next-state logic for the whole controller
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.rsp.done = 1'b0;
        nxt_s.rsp.fail = 1'b0;
        unique case (s_ff.st)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    nxt_s.op     = req.op;
                    nxt_s.addr   = req.addr;
                    nxt_s.wdata  = req.data;
                    nxt_s.cnt    = '0;
                    nxt_s.polls  = '0;
                    nxt_s.wr_idx = 1'b0;
                    nxt_s.fail   = 1'b0;
                    if (req.op == OP_READ) begin
                        nxt_s.st = ST_RD;
                    end else begin
                        nxt_s.pin.vpp_en = 1'b1;
                        nxt_s.st         = ST_VPP;
                    end
                end
            end
            ST_VPP: begin
                // Let the programming supply settle before any command write
                if (s_ff.cnt == 8'(VPP_CYC - 1)) begin
                    nxt_s.cnt = '0;
                    nxt_s.st  = ST_WR;
                end else begin
                    nxt_s.cnt = s_ff.cnt + 8'h01;
                end
            end
            ST_WR: begin
                // One write cycle: select, strobe low for WP_CYC, strobe high, deselect
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == 8'h00) begin
                    nxt_s.pin.ce_n           = 1'b0;
                    nxt_s.pin.oe_n           = 1'b1;
                    nxt_s.pin.address_lines  = s_ff.addr;
                    nxt_s.pin.data_lines_out = cmd_byte(s_ff.op, s_ff.wr_idx, s_ff.wdata);
                    nxt_s.pin.data_lines_oe  = 1'b1;
                end else if (s_ff.cnt == 8'h01) begin
                    nxt_s.pin.we_n = 1'b0;
                end else if (s_ff.cnt == 8'(WP_CYC + 1)) begin
                    nxt_s.pin.we_n = 1'b1;
                end else if (s_ff.cnt == 8'(WP_CYC + 2)) begin
                    nxt_s.pin.ce_n = 1'b1;
                end else if (s_ff.cnt == 8'(WP_CYC + 3)) begin
                    // Data held past the strobe edge, then the bus is released
                    nxt_s.pin.data_lines_oe = 1'b0;
                    nxt_s.cnt               = '0;
                    if (!s_ff.wr_idx) begin
                        nxt_s.wr_idx = 1'b1;
                    end else begin
                        nxt_s.st = ST_RD;
                    end
                end
            end
            ST_RD: begin
                // Read cycle; data sampled after access time plus synchroniser delay
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == 8'h00) begin
                    nxt_s.pin.address_lines = s_ff.addr;
                    nxt_s.pin.ce_n          = 1'b0;
                    nxt_s.pin.oe_n          = 1'b0;
                end else if (s_ff.cnt == 8'(RD_CYC)) begin
                    nxt_s.rsp.rdata = dq_sync;
                    nxt_s.pin.ce_n  = 1'b1;
                    nxt_s.pin.oe_n  = 1'b1;
                    nxt_s.cnt       = '0;
                    nxt_s.st        = ST_CHK;
                end
            end
            ST_CHK: begin
                // Poll the status bit until the internal sequence ends or time runs out
                if (s_ff.op == OP_READ) begin
                    nxt_s.st = ST_FIN;
                end else if (poll_done(s_ff.op, s_ff.wdata, s_ff.rsp.rdata)) begin
                    nxt_s.st = ST_FIN;
                end else if (s_ff.polls == POLL_LIMIT) begin
                    nxt_s.fail = 1'b1;
                    nxt_s.st   = ST_FIN;
                end else begin
                    nxt_s.polls = s_ff.polls + 24'h000001;
                    nxt_s.st    = ST_RD;
                end
            end
            ST_FIN: begin
                nxt_s.pin.vpp_en = 1'b0;
                nxt_s.rsp.done   = 1'b1;
                nxt_s.rsp.fail   = s_ff.fail;
                nxt_s.st         = ST_IDLE;
            end
        endcase
        // Logic supply below lockout: strobes parked, supply off, operation aborted
        if (!supply_sync) begin
            nxt_s.pin = PIN_IDLE;
            nxt_s.cnt = '0;
            if (s_ff.st != ST_IDLE) begin
                nxt_s.rsp.done = 1'b1;
                nxt_s.rsp.fail = 1'b1;
                nxt_s.st       = ST_IDLE;
            end
        end
    end

    // State register; reset parks every strobe high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= HOST_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pins = s_ff.pin;
    assign resp = s_ff.rsp;

endmodule : flash_cmd_host
`default_nettype wire

// ### flash_host_pkg.sv
// Package: pin bundles, request/answer types and timing constants for the flash host
`default_nettype none
package flash_host_pkg;

    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 8;
    localparam int CLK_MHZ     = 20;
    localparam int SYNC_STAGES = 2;

    // Least write strobe low time and read access time, in ns
    localparam int T_WP_NS  = 100;
    localparam int T_ACC_NS = 200;
    // Least settling time of the programming supply after switch-on, in ns
    localparam int T_VPP_NS = 1000;

    // Least times round up to whole cycles
    localparam int WP_CYC  = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int VPP_CYC = (T_VPP_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC  = ACC_CYC + SYNC_STAGES;

    // Bit of the data lines that carries the polled status
    localparam int POLL_BIT = 7;

    typedef enum logic [1:0] {
        OP_READ,
        OP_PROG,
        OP_ERASE
    } op_t;

    typedef struct packed {
        op_t                 op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } req_t;

    typedef struct packed {
        logic                done;
        logic                fail;
        logic [DATA_W-1:0]   rdata;
    } resp_t;

    typedef struct packed {
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic [ADDR_W-1:0]   address_lines;
        logic [DATA_W-1:0]   data_lines_out;
        logic                data_lines_oe;
        logic                vpp_en;
    } pin_out_t;

    // Pins after reset: every strobe high, bus released, no programming supply
    localparam pin_out_t PIN_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      address_lines: '0, data_lines_out: '0,
                                      data_lines_oe: 1'b0, vpp_en: 1'b0};
    localparam resp_t    RESP_IDLE = '{done: 1'b0, fail: 1'b0, rdata: '0};

endpackage : flash_host_pkg
`default_nettype wire

// ### sync2.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : sync2
`default_nettype wire

// ### flash_cmd_host_assertions.sv
// Pin-protocol assertions for the flash host controller
`default_nettype none
module flash_cmd_host_chk
    import flash_host_pkg::*;
(
    input wire logic                                clk,
    input wire logic                                arst_n,
    input wire logic                                req_valid,
    input wire logic                                req_ready,
    input wire flash_host_pkg::req_t                req,
    input wire flash_host_pkg::resp_t               resp,
    input wire flash_host_pkg::pin_out_t            pins,
    input wire logic [flash_host_pkg::DATA_W-1:0]   data_lines_in,
    input wire logic                                supply_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_WRITE_STROBES: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
        else $error("write strobe low without select or with output enable low");
    AST_OE_QUIET: assert property (!pins.oe_n |-> pins.we_n && !pins.data_lines_oe)
        else $error("read strobe low during a write");
    AST_WRITE_HAS_VPP: assert property (!pins.we_n |-> pins.vpp_en && pins.data_lines_oe)
        else $error("write without programming supply or data");
    AST_LOCKOUT_IDLE: assert property (!supply_ok [*4] |-> pins.we_n && pins.ce_n)
        else $error("strobes active with logic supply low");
    AST_WE_WIDTH: assert property ($fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n)
        else $error("write strobe not two cycles low");
    AST_DATA_HOLD: assert property ($rose(pins.we_n) |->
        (!pins.ce_n && pins.data_lines_oe) ##1 pins.ce_n)
        else $error("select or data released before write strobe rose");
    AST_DONE_PULSE: assert property (resp.done |=> !resp.done)
        else $error("done longer than one cycle");
    AST_READY_IDLE: assert property (req_ready |-> !pins.vpp_en && pins.ce_n)
        else $error("ready while an operation holds the pins");
endmodule : flash_cmd_host_chk
`default_nettype wire

// ### flash_dev_model.sv
// Behavioural model of the bulk-erase flash device at its pins
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] PROG_SETUP  = 8'h01,
    parameter logic [7:0] ERASE_SETUP = 8'h02,
    parameter logic [7:0] ERASE_GO    = 8'h03
) (
    input  wire flash_host_pkg::pin_out_t     pins,
    input  wire logic                         supply_ok,
    input  wire logic                         stuck,
    input  wire logic [3:0]                   busy_polls,
    output logic [flash_host_pkg::DATA_W-1:0] data_lines_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [0:32767];
    logic [14:0] lat_addr = '0;
    logic [7:0]  last = '0, pend = '0, sel_val;
    logic [1:0]  mode = '0;
    logic [3:0]  busy = '0;
    logic        erasing = 1'b0, armed = 1'b0;
    time         t_fall = 0;
    wire         wr_off = pins.ce_n | pins.we_n | ~pins.oe_n;
    wire         rd_on = ~pins.ce_n & ~pins.oe_n;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // Address taken as the later strobe falls
    always @(negedge wr_off) begin
        lat_addr = pins.address_lines;
        armed = 1'b1;
        t_fall = $time;
    end
    // Data taken as the earlier strobe rises; commands need the high supply
    always @(posedge wr_off) begin
        // Strobe pulses shorter than 10 ns are treated as noise and start nothing
        if (armed && ($time - t_fall) >= 10 && pins.vpp_en && supply_ok &&
            busy == 4'h0) begin
            if (mode == 2'h1) begin
                mem[lat_addr] = pins.data_lines_out;
                pend = pins.data_lines_out;
                busy = busy_polls;
                mode = 2'h0;
            end else if (mode == 2'h2 && pins.data_lines_out == ERASE_GO) begin
                foreach (mem[i]) mem[i] = 8'hFF;
                erasing = 1'b1;
                busy = busy_polls;
                mode = 2'h0;
            end else begin
                mode = (pins.data_lines_out == PROG_SETUP) ? 2'h1 :
                       (pins.data_lines_out == ERASE_SETUP) ? 2'h2 : 2'h0;
            end
        end
    end
    // Logic supply below lockout drops back to read mode
    always @(negedge supply_ok) begin
        mode = 2'h0;
        busy = 4'h0;
        erasing = 1'b0;
    end
    // Status bit inverted while busy; released lines show the inverse of the last value
    always_comb sel_val = (busy == 4'h0) ? mem[pins.address_lines] :
                          erasing ? 8'h00 : {~pend[7], pend[6:0]};
    assign data_lines_in = rd_on ? sel_val : ~last;
    // Each finished status read advances the internal sequence unless stuck is high
    always @(negedge rd_on) begin
        last = sel_val;
        if (busy != 4'h0 && !stuck) busy = busy - 4'h1;
        if (busy == 4'h0) erasing = 1'b0;
    end
endmodule : flash_dev_model
`default_nettype wire

// ### tb_flash_cmd_host.sv
// Self-checking bench for the flash host controller
`default_nettype none
`define CHK(g, e) if ((g) !== (e)) begin \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    error_cnt++; \
end n_checks++;
module tb_flash_cmd_host import flash_host_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {op_t op; logic [14:0] a; logic [7:0] d; logic [7:0] exp;} row_t;
    logic         clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, supply_ok = 1'b1, stuck = 1'b0;
    logic         req_ready;
    logic [7:0]   data_lines_in;
    req_t         req = '0;
    resp_t        resp, r;
    pin_out_t     pins;
    int           error_cnt = 0, n_checks = 0;
    row_t         rows [7] = '{'{OP_PROG, 15'h1234, 8'hA5, 8'hA5},
        '{OP_READ, 15'h1234, 8'h00, 8'hA5},
        '{OP_PROG, 15'h7FFF, 8'h3C, 8'h3C}, '{OP_READ, 15'h7FFF, 8'h00, 8'h3C},
        '{OP_READ, 15'h0000, 8'h00, 8'hFF}, '{OP_ERASE, 15'h1234, 8'h00, 8'hFF},
        '{OP_READ, 15'h7FFF, 8'h00, 8'hFF}};
    always #25 clk = ~clk;
    flash_cmd_host #(.POLL_LIMIT(24'h000004)) u_flash_cmd_host (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .resp(resp), .pins(pins),
        .data_lines_in(data_lines_in), .supply_ok(supply_ok));
    flash_dev_model u_flash_dev_model (.pins(pins), .supply_ok(supply_ok), .stuck(stuck),
        .busy_polls(4'h3), .data_lines_in(data_lines_in));
    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // One request: hold valid until taken, then wait a bounded time for done
    task automatic run_req(input op_t op, input logic [14:0] a, input logic [7:0] d,
                           output resp_t rr);
        int n;
        @(negedge clk);
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
        // A request never taken counts as a mismatch
        if (req_ready !== 1'b1) error_cnt++;
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 3000 && resp.done !== 1'b1; n++) @(negedge clk);
        rr = resp;
        if (resp.done !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
    endtask : run_req
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        foreach (rows[i]) begin
            run_req(rows[i].op, rows[i].a, rows[i].d, r);
            `CHK(r.fail, 1'b0)
            `CHK(r.rdata, rows[i].exp)
        end
        // Device that never finishes: the poll limit ends the request failed
        stuck = 1'b1;
        run_req(OP_PROG, 15'h0100, 8'h5A, r);
        `CHK(r.fail, 1'b1)
        // Logic supply lost while polling: request ends failed, nothing taken
        fork
            run_req(OP_PROG, 15'h0200, 8'h5A, r);
            begin
                repeat (45) @(negedge clk);
                supply_ok = 1'b0;
            end
        join
        `CHK(r.fail, 1'b1)
        `CHK(req_ready, 1'b0)
        supply_ok = 1'b1;
        stuck = 1'b0;
        // Reset in mid-operation puts every pin back to idle; array untouched
        req = '{op: OP_ERASE, addr: 15'h0000, data: 8'h00};
        req_valid = 1'b1;
        repeat (25) @(negedge clk);
        req_valid = 1'b0;
        arst_n = 1'b0;
        @(negedge clk);
        `CHK(pins, PIN_IDLE)
        arst_n = 1'b1;
        // Aborted erase left the earlier program intact; the write while busy was ignored
        run_req(OP_READ, 15'h0100, 8'h00, r);
        `CHK(r.rdata, 8'h5A)
        run_req(OP_READ, 15'h0200, 8'h00, r);
        `CHK(r.rdata, 8'hFF)
        end_of_test();
    end
endmodule : tb_flash_cmd_host
bind flash_cmd_host flash_cmd_host_chk u_chk (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp(resp), .pins(pins),
    .data_lines_in(data_lines_in), .supply_ok(supply_ok));
`default_nettype wire
